//--- rtl/ipw_pkg.sv
package ipw_pkg;

  // i/o port pair and key values
  localparam logic [15:0] IPW_PORT_INDEX = 16'h002e;
  localparam logic [15:0] IPW_PORT_DATA  = 16'h002f;
  localparam logic [7:0]  IPW_KEY_UNLOCK = 8'h87;
  localparam logic [7:0]  IPW_KEY_LOCK   = 8'haa;

  // register indices
  localparam logic [7:0]  IPW_IDX_LDN    = 8'h07;
  localparam logic [7:0]  IPW_IDX_ACT    = 8'h30;
  localparam logic [7:0]  IPW_IDX_UNIT   = 8'hf5;
  localparam logic [7:0]  IPW_IDX_COUNT  = 8'hf6;
  localparam logic [7:0]  IPW_IDX_CTRL   = 8'hf7;
  localparam logic [7:0]  IPW_LDN_WDT    = 8'h08;

  // field positions
  localparam int          IPW_ACT_EN     = 0;
  localparam int          IPW_UNIT_MIN   = 3;
  localparam int          IPW_UNIT_FAST  = 4;
  localparam int          IPW_CTRL_MOUSE = 7;
  localparam int          IPW_CTRL_KBD   = 6;
  localparam int          IPW_CTRL_FORCE = 5;
  localparam int          IPW_CTRL_STAT  = 4;

  // reset and read-back values
  localparam logic [7:0]  IPW_RST_BYTE   = 8'h00;
  localparam logic [7:0]  IPW_RD_NONE    = 8'hff;

  // timing: base tick is one millisecond
  localparam int unsigned IPW_CLK_NS     = 8;
  localparam int unsigned IPW_TICK_NS    = 1000000;
  localparam int unsigned IPW_MS_CYCLES  = IPW_TICK_NS / IPW_CLK_NS;
  localparam logic [15:0] IPW_MS_PER_SEC = 16'h03e8;
  localparam logic [15:0] IPW_SEC_PER_MIN = 16'h003c;
  localparam logic [15:0] IPW_ONE_MS     = 16'h0001;

  typedef enum logic [1:0] {
    IPW_LOCKED,
    IPW_KEY1,
    IPW_OPEN
  } ipw_lock_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } ipw_io_req_t;

  typedef struct packed {
    logic        valid;
    logic [7:0]  data;
  } ipw_io_rsp_t;

endpackage

//--- rtl/ipw_watchdog.sv
// Notes on behaviour
// - index port selects, data port transfers
// - two unlock keys in a row open access
// - device number eight selects watchdog registers
// - activation bit enables; disabled after reset
// - unit bit three: seconds or minutes
// - unit bit four: thousand times faster
// - count zero stops; one to 255 interval
// - count write reloads and restarts counting
// - expiry asserts the timeout output
// - control bit six: keyboard restarts counter
// - control bit seven: mouse restarts counter
// - control bit five forces timeout, self-clears
// - control bit four reads timeout status
`timescale 1ns/1ns
module ipw_watchdog #(
  parameter int unsigned MS_CYCLES = ipw_pkg::IPW_MS_CYCLES
) (
  input  wire logic                 sys_clk_i,
  input  wire logic                 nrst_i,
  input  wire ipw_pkg::ipw_io_req_t io_req_i,
  input  wire logic                 kbd_act_i,
  input  wire logic                 mouse_act_i,
  output ipw_pkg::ipw_io_rsp_t      io_rsp_o,
  output logic                      wdt_timeout_o
);
  import ipw_pkg::*;
  default clocking cb_sva @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);

  function automatic logic [15:0] unit_ms(input logic minutes, input logic fast);
    logic [15:0] base;
    base = fast ? IPW_ONE_MS : IPW_MS_PER_SEC;
    unit_ms = minutes ? 16'(base * IPW_SEC_PER_MIN) : base;
  endfunction

  ipw_lock_t   lock_r,  lock_nxt;
  logic [7:0]  idx_r,   idx_nxt;
  logic [7:0]  ldn_r,   ldn_nxt;
  logic [7:0]  act_r,   act_nxt;
  logic [7:0]  unit_r,  unit_nxt;
  logic [7:0]  load_r,  load_nxt;
  logic [7:0]  cnt_r,   cnt_nxt;
  logic        kbd_en_r, kbd_en_nxt;
  logic        ms_en_r, ms_en_nxt;
  logic        stat_r,  stat_nxt;
  logic [23:0] pre_r,   pre_nxt;
  logic [15:0] sub_r,   sub_nxt;
  logic [2:0]  kbd_s_r, kbd_s_nxt;
  logic [2:0]  ms_s_r,  ms_s_nxt;
  ipw_io_rsp_t rsp_r,   rsp_nxt;

  logic        wr_index;
  logic        wr_data;
  logic        wdt_sel;
  logic        kbd_edge;
  logic        ms_edge;
  logic        restart;
  logic        force_to;
  logic        expire;
  logic [15:0] limit;

  always_comb begin
    lock_nxt   = lock_r;
    idx_nxt    = idx_r;
    ldn_nxt    = ldn_r;
    act_nxt    = act_r;
    unit_nxt   = unit_r;
    load_nxt   = load_r;
    cnt_nxt    = cnt_r;
    kbd_en_nxt = kbd_en_r;
    ms_en_nxt  = ms_en_r;
    stat_nxt   = stat_r;
    pre_nxt    = pre_r;
    sub_nxt    = sub_r;
    force_to   = 1'b0;
    expire     = 1'b0;
    rsp_nxt    = '0;

    // pins pass two flops; edge taken from the second and third
    kbd_s_nxt  = {kbd_s_r[1:0], kbd_act_i};
    ms_s_nxt   = {ms_s_r[1:0], mouse_act_i};
    kbd_edge   = kbd_s_r[1] & ~kbd_s_r[2];
    ms_edge    = ms_s_r[1] & ~ms_s_r[2];

    wr_index   = io_req_i.wr && (io_req_i.addr == IPW_PORT_INDEX);
    wr_data    = io_req_i.wr && (io_req_i.addr == IPW_PORT_DATA)
                 && (lock_r == IPW_OPEN);
    wdt_sel    = (ldn_r == IPW_LDN_WDT);
    limit      = unit_ms(unit_r[IPW_UNIT_MIN], unit_r[IPW_UNIT_FAST]);
    restart    = (kbd_edge && kbd_en_r) || (ms_edge && ms_en_r);

    case (lock_r)
      IPW_LOCKED: begin
        if (wr_index && io_req_i.wdata == IPW_KEY_UNLOCK) begin
          lock_nxt = IPW_KEY1;
        end
      end
      IPW_KEY1: begin
        if (wr_index) begin
          lock_nxt = (io_req_i.wdata == IPW_KEY_UNLOCK) ? IPW_OPEN : IPW_LOCKED;
        end
      end
      IPW_OPEN: begin
        if (wr_index) begin
          if (io_req_i.wdata == IPW_KEY_LOCK) begin
            lock_nxt = IPW_LOCKED;
          end else begin
            idx_nxt = io_req_i.wdata;
          end
        end
      end
      default: lock_nxt = IPW_LOCKED;
    endcase

    // unit tick and countdown
    if (act_r[IPW_ACT_EN] && cnt_r != IPW_RST_BYTE) begin
      if (pre_r == 24'(MS_CYCLES - 1)) begin
        pre_nxt = '0;
        if (sub_r + IPW_ONE_MS >= limit) begin
          sub_nxt = '0;
          cnt_nxt = cnt_r - 8'h01;
          expire  = (cnt_r == 8'h01);
        end else begin
          sub_nxt = sub_r + IPW_ONE_MS;
        end
      end else begin
        pre_nxt = pre_r + 24'h000001;
      end
    end

    if (restart) begin
      cnt_nxt = load_r;
      pre_nxt = '0;
      sub_nxt = '0;
    end

    if (wr_data) begin
      if (idx_r == IPW_IDX_LDN) begin
        ldn_nxt = io_req_i.wdata;
      end else if (wdt_sel) begin
        case (idx_r)
          IPW_IDX_ACT:  act_nxt  = io_req_i.wdata;
          IPW_IDX_UNIT: unit_nxt = io_req_i.wdata;
          IPW_IDX_COUNT: begin
            load_nxt = io_req_i.wdata;
            cnt_nxt  = io_req_i.wdata;
            pre_nxt  = '0;
            sub_nxt  = '0;
            stat_nxt = 1'b0;
          end
          IPW_IDX_CTRL: begin
            ms_en_nxt  = io_req_i.wdata[IPW_CTRL_MOUSE];
            kbd_en_nxt = io_req_i.wdata[IPW_CTRL_KBD];
            force_to   = io_req_i.wdata[IPW_CTRL_FORCE];
          end
          default: ;
        endcase
      end
    end

    // set wins over the clear from a count write
    if (expire || force_to) begin
      stat_nxt = 1'b1;
    end

    if (io_req_i.rd) begin
      rsp_nxt.valid = 1'b1;
      rsp_nxt.data  = IPW_RD_NONE;
      if (io_req_i.addr == IPW_PORT_INDEX && lock_r == IPW_OPEN) begin
        rsp_nxt.data = idx_r;
      end else if (io_req_i.addr == IPW_PORT_DATA && lock_r == IPW_OPEN) begin
        if (idx_r == IPW_IDX_LDN) begin
          rsp_nxt.data = ldn_r;
        end else if (wdt_sel) begin
          case (idx_r)
            IPW_IDX_ACT:   rsp_nxt.data = act_r;
            IPW_IDX_UNIT:  rsp_nxt.data = unit_r;
            IPW_IDX_COUNT: rsp_nxt.data = load_r;
            IPW_IDX_CTRL: begin
              rsp_nxt.data = IPW_RST_BYTE;
              rsp_nxt.data[IPW_CTRL_MOUSE] = ms_en_r;
              rsp_nxt.data[IPW_CTRL_KBD]   = kbd_en_r;
              rsp_nxt.data[IPW_CTRL_STAT]  = stat_r;
            end
            default: rsp_nxt.data = IPW_RD_NONE;
          endcase
        end
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      lock_r   <= IPW_LOCKED;
      idx_r    <= IPW_RST_BYTE;
      ldn_r    <= IPW_RST_BYTE;
      act_r    <= IPW_RST_BYTE;
      unit_r   <= IPW_RST_BYTE;
      load_r   <= IPW_RST_BYTE;
      cnt_r    <= IPW_RST_BYTE;
      kbd_en_r <= 1'b0;
      ms_en_r  <= 1'b0;
      stat_r   <= 1'b0;
      pre_r    <= '0;
      sub_r    <= '0;
      kbd_s_r  <= '0;
      ms_s_r   <= '0;
      rsp_r    <= '0;
    end else begin
      lock_r   <= lock_nxt;
      idx_r    <= idx_nxt;
      ldn_r    <= ldn_nxt;
      act_r    <= act_nxt;
      unit_r   <= unit_nxt;
      load_r   <= load_nxt;
      cnt_r    <= cnt_nxt;
      kbd_en_r <= kbd_en_nxt;
      ms_en_r  <= ms_en_nxt;
      stat_r   <= stat_nxt;
      pre_r    <= pre_nxt;
      sub_r    <= sub_nxt;
      kbd_s_r  <= kbd_s_nxt;
      ms_s_r   <= ms_s_nxt;
      rsp_r    <= rsp_nxt;
    end
  end

  assign io_rsp_o      = rsp_r;
  assign wdt_timeout_o = stat_r;

  property p_unlock_two_keys;
    (lock_r == IPW_KEY1 && wr_index && io_req_i.wdata == IPW_KEY_UNLOCK)
      |=> (lock_r == IPW_OPEN);
  endproperty
  a_unlock_two_keys: assert property (p_unlock_two_keys)
    else $error("second key did not open");
  property p_locked_ignores_data;
    (lock_r != IPW_OPEN && !restart && !(act_r[IPW_ACT_EN] && cnt_r != IPW_RST_BYTE))
      |=> $stable(load_r) && $stable(act_r) && $stable(cnt_r);
  endproperty
  a_locked_ignores_data: assert property (p_locked_ignores_data)
    else $error("locked write took");
  property p_lock_key;
    (lock_r == IPW_OPEN && wr_index && io_req_i.wdata == IPW_KEY_LOCK)
      |=> (lock_r == IPW_LOCKED) ##1 (lock_r != IPW_OPEN);
  endproperty
  a_lock_key: assert property (p_lock_key) else $error("lock key did not lock");
  property p_other_ldn_blocks;
    (wr_data && !wdt_sel && idx_r == IPW_IDX_ACT) |=> $stable(act_r);
  endproperty
  a_other_ldn_blocks: assert property (p_other_ldn_blocks)
    else $error("unselected write took");
  property p_disabled_frozen;
    (!act_r[IPW_ACT_EN] && !restart && !wr_data) |=> $stable(cnt_r) && $stable(pre_r);
  endproperty
  a_disabled_frozen: assert property (p_disabled_frozen)
    else $error("counter ran while off");
  property p_count_reload;
    (wr_data && wdt_sel && idx_r == IPW_IDX_COUNT)
      |=> (cnt_r == $past(io_req_i.wdata)) && (load_r == cnt_r) && (pre_r == '0);
  endproperty
  a_count_reload: assert property (p_count_reload)
    else $error("count write did not reload");
  property p_step_on_tick;
    (cnt_r != IPW_RST_BYTE && act_r[IPW_ACT_EN] && !restart && !wr_data
     && (pre_r != 24'(MS_CYCLES - 1) || sub_r + IPW_ONE_MS < limit)) |=> $stable(cnt_r);
  endproperty
  a_step_on_tick: assert property (p_step_on_tick)
    else $error("count stepped off tick");
  property p_expiry;
    (cnt_r == 8'h01 && cnt_nxt == IPW_RST_BYTE && !restart && !wr_data)
      |=> stat_r && wdt_timeout_o ##1 (stat_r || $past(wr_data));
  endproperty
  a_expiry: assert property (p_expiry) else $error("expiry did not time out");
  property p_force;
    (wr_data && wdt_sel && idx_r == IPW_IDX_CTRL && io_req_i.wdata[IPW_CTRL_FORCE])
      |=> wdt_timeout_o;
  endproperty
  a_force: assert property (p_force) else $error("force did not time out");
  property p_force_reads_zero;
    (io_req_i.rd && io_req_i.addr == IPW_PORT_DATA && lock_r == IPW_OPEN && wdt_sel
     && idx_r == IPW_IDX_CTRL)
      |=> io_rsp_o.valid && !io_rsp_o.data[IPW_CTRL_FORCE]
          && (io_rsp_o.data[IPW_CTRL_STAT] == $past(stat_r));
  endproperty
  a_force_reads_zero: assert property (p_force_reads_zero)
    else $error("control readback wrong");
  property p_activity_restart;
    (kbd_edge && kbd_en_r && !wr_data) |=> (cnt_r == $past(load_r));
  endproperty
  a_activity_restart: assert property (p_activity_restart)
    else $error("keyboard restart failed");
endmodule

//--- verif/test_indexed_port_watchdog_timer.sv
`timescale 1ns/1ns
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("wrong value %s expected %h seen %h", nm, e, g); end end
module test_indexed_port_watchdog_timer;
  import ipw_pkg::*;

  typedef struct packed {
    logic [7:0] idx;
    logic [7:0] wd;
    logic [7:0] exp;
  } ipw_row_t;

  logic         sys_clk;
  logic         nrst;
  ipw_io_req_t  req;
  ipw_io_rsp_t  rsp;
  logic         kbd;
  logic         mouse;
  logic         tmo;
  int           fail_count;
  int           total_checks;
  ipw_row_t     rows [6];

  ipw_watchdog #(.MS_CYCLES(4)) uut (
    .sys_clk_i     (sys_clk),
    .nrst_i        (nrst),
    .io_req_i      (req),
    .kbd_act_i     (kbd),
    .mouse_act_i   (mouse),
    .io_rsp_o      (rsp),
    .wdt_timeout_o (tmo)
  );

  always #4 sys_clk = ~sys_clk;

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    req.wr    = 1'b1;
    req.addr  = a;
    req.wdata = d;
    @(negedge sys_clk);
    req.wr    = 1'b0;
  endtask

  // one-cycle read strobe, answer picked up as the strobe drops
  task automatic rd(input logic [15:0] a, input logic [7:0] e, input string nm);
    logic [7:0] got;
    @(negedge sys_clk);
    req.rd   = 1'b1;
    req.addr = a;
    @(negedge sys_clk);
    req.rd   = 1'b0;
    got = rsp.data;
    `CHK({nm, " valid"}, 1'b1, rsp.valid)
    `CHK(nm, e, got)
  endtask

  task automatic wreg(input logic [7:0] i, input logic [7:0] d);
    wr(IPW_PORT_INDEX, i);
    wr(IPW_PORT_DATA, d);
  endtask

  task automatic rreg(input logic [7:0] i, input logic [7:0] e, input string nm);
    wr(IPW_PORT_INDEX, i);
    rd(IPW_PORT_DATA, e, nm);
  endtask

  // count cycles from now until the timeout output rises
  task automatic wait_to(input int lo, input int hi);
    int n;
    n = 0;
    while (tmo !== 1'b1 && n <= hi) begin
      @(negedge sys_clk);
      n++;
    end
    `CHK("expiry in window", 1'b1, (n >= lo && n <= hi))
  endtask

  // pulses on one activity pin, wide enough for the synchroniser
  task automatic pulse(input bit use_mouse, input int cnt);
    repeat (cnt) begin
      @(negedge sys_clk);
      if (use_mouse) mouse = 1'b1; else kbd = 1'b1;
      repeat (4) @(negedge sys_clk);
      mouse = 1'b0;
      kbd   = 1'b0;
      repeat (5) @(negedge sys_clk);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    #480000;
    fail_count++;
    give_verdict();
  end

  initial begin
    sys_clk = 1'b0;
    nrst    = 1'b0;
    req     = '0;
    kbd     = 1'b0;
    mouse   = 1'b0;
    fail_count   = 0;
    total_checks = 0;
    rows[0] = '{8'h30, 8'h01, 8'h01};
    rows[1] = '{8'hf5, 8'h18, 8'h18};
    rows[2] = '{8'hf5, 8'h10, 8'h10};
    rows[3] = '{8'hf7, 8'hc0, 8'hc0};
    rows[4] = '{8'hf7, 8'h00, 8'h00};
    rows[5] = '{8'h55, 8'haa, 8'hff};
    repeat (8) @(negedge sys_clk);
    nrst = 1'b1;
    `CHK("timeout after reset", 1'b0, tmo)
    rd(IPW_PORT_DATA, 8'hff, "locked data");
    wr(IPW_PORT_INDEX, IPW_KEY_UNLOCK);
    wr(IPW_PORT_INDEX, IPW_IDX_LDN);
    wr(IPW_PORT_INDEX, IPW_KEY_UNLOCK);
    rreg(IPW_IDX_LDN, 8'hff, "broken key");
    wr(IPW_PORT_INDEX, IPW_KEY_UNLOCK);
    wr(IPW_PORT_INDEX, IPW_KEY_UNLOCK);
    rreg(IPW_IDX_LDN, 8'h00, "device select reset");
    rreg(IPW_IDX_ACT, 8'hff, "unselected device");
    wreg(IPW_IDX_ACT, 8'h01);
    wreg(IPW_IDX_LDN, IPW_LDN_WDT);
    rreg(IPW_IDX_ACT, 8'h00, "activation reset");
    rreg(IPW_IDX_UNIT, 8'h00, "unit reset");
    rreg(IPW_IDX_COUNT, 8'h00, "count reset");
    rreg(IPW_IDX_CTRL, 8'h00, "control reset");
    foreach (rows[k]) begin
      wreg(rows[k].idx, rows[k].wd);
      rreg(rows[k].idx, rows[k].exp, "row readback");
    end
    // fast seconds: one unit is four clocks here
    wreg(IPW_IDX_COUNT, 8'h03);
    wait_to(9, 16);
    rreg(IPW_IDX_CTRL, 8'h10, "status set");
    wreg(IPW_IDX_COUNT, 8'h00);
    repeat (40) @(negedge sys_clk);
    `CHK("zero count stops", 1'b0, tmo)
    wreg(IPW_IDX_UNIT, 8'h18);
    wreg(IPW_IDX_COUNT, 8'h01);
    wait_to(236, 246);
    wreg(IPW_IDX_UNIT, 8'h00);
    wreg(IPW_IDX_COUNT, 8'h01);
    wait_to(3996, 4006);
    // plain minutes must outlast a seconds interval
    wreg(IPW_IDX_UNIT, 8'h08);
    wreg(IPW_IDX_COUNT, 8'h01);
    repeat (4010) @(negedge sys_clk);
    `CHK("minutes outlast seconds", 1'b0, tmo)
    wreg(IPW_IDX_COUNT, 8'h00);
    // activity restart with a 20-clock interval
    wreg(IPW_IDX_UNIT, 8'h10);
    wreg(IPW_IDX_CTRL, 8'h40);
    wreg(IPW_IDX_COUNT, 8'h05);
    pulse(1'b0, 6);
    `CHK("keyboard holds off", 1'b0, tmo)
    wait_to(1, 30);
    wreg(IPW_IDX_CTRL, 8'h80);
    wreg(IPW_IDX_COUNT, 8'h05);
    pulse(1'b1, 6);
    `CHK("mouse holds off", 1'b0, tmo)
    wreg(IPW_IDX_CTRL, 8'h00);
    wreg(IPW_IDX_COUNT, 8'h05);
    pulse(1'b0, 3);
    `CHK("keyboard ignored", 1'b1, tmo)
    // forced timeout while disabled
    wreg(IPW_IDX_ACT, 8'h00);
    wreg(IPW_IDX_COUNT, 8'h00);
    `CHK("status cleared", 1'b0, tmo)
    wreg(IPW_IDX_CTRL, 8'h20);
    wait_to(0, 3);
    rreg(IPW_IDX_CTRL, 8'h10, "force self clear");
    wr(IPW_PORT_INDEX, IPW_KEY_LOCK);
    rd(IPW_PORT_DATA, 8'hff, "after lock");
    // data write refused while locked, then a reset with the timeout status set
    wr(IPW_PORT_DATA, 8'hc0);
    wr(IPW_PORT_INDEX, IPW_KEY_UNLOCK);
    wr(IPW_PORT_INDEX, IPW_KEY_UNLOCK);
    rreg(IPW_IDX_CTRL, 8'h10, "locked write ignored");
    wreg(IPW_IDX_ACT, 8'h01);
    nrst = 1'b0;
    repeat (3) @(negedge sys_clk);
    nrst = 1'b1;
    `CHK("timeout after second reset", 1'b0, tmo)
    wr(IPW_PORT_INDEX, IPW_KEY_UNLOCK);
    wr(IPW_PORT_INDEX, IPW_KEY_UNLOCK);
    rreg(IPW_IDX_LDN, 8'h00, "select after reset");
    wreg(IPW_IDX_LDN, IPW_LDN_WDT);
    rreg(IPW_IDX_ACT, 8'h00, "activation after reset");
    give_verdict();
  end
endmodule
